// File: rtl/sih_aes.sv
// Purpose: iterative AES-128 encryptor, one round per clock
// Assumes: key and plain are stable in the start cycle only
// Notes: done pulses one cycle; cipher holds until the next start
`default_nettype none
module sih_aes (
   input wire logic clock,
   input wire logic srst,
   input wire logic start,
   input wire logic [127:0] key,
   input wire logic [127:0] plain,
   output logic busy,
   output logic done,
   output logic [127:0] cipher
);
   logic [127:0] rk;
   logic [7:0] rcon;
   logic [3:0] rnd;
   logic [127:0] shifted;
   logic [127:0] next_rk;
   logic [127:0] next_block;
   logic [31:0] tw;

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            shifted[127 - 8 * (4 * c + r) -: 8] =
               sih_pkg::sih_sbox(cipher[127 - 8 * (4 * ((c + r) % 4) + r) -: 8]);
         end
      end
      // Key schedule runs on the fly, so no expanded key storage
      tw = {sih_pkg::sih_sbox(rk[23:16]) ^ rcon, sih_pkg::sih_sbox(rk[15:8]),
            sih_pkg::sih_sbox(rk[7:0]), sih_pkg::sih_sbox(rk[31:24])};
      next_rk[127:96] = rk[127:96] ^ tw;
      next_rk[95:64] = rk[95:64] ^ next_rk[127:96];
      next_rk[63:32] = rk[63:32] ^ next_rk[95:64];
      next_rk[31:0] = rk[31:0] ^ next_rk[63:32];
      for (int c = 0; c < 4; c++) begin
         if (rnd == sih_pkg::AES_ROUNDS) next_block[127 - 32 * c -: 32] = shifted[127 - 32 * c -: 32];
         else next_block[127 - 32 * c -: 32] = sih_pkg::sih_mixcol(shifted[127 - 32 * c -: 32]);
      end
      next_block = next_block ^ next_rk;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         busy <= 1'b0;
         done <= 1'b0;
         rnd <= 4'h0;
         rcon <= 8'h00;
         rk <= 128'h0;
         cipher <= 128'h0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            cipher <= plain ^ key;
            rk <= key;
            rcon <= sih_pkg::AES_RCON_INIT;
            rnd <= 4'h1;
            busy <= 1'b1;
         end else if (busy) begin
            cipher <= next_block;
            rk <= next_rk;
            rcon <= sih_pkg::sih_xtime(rcon);
            rnd <= rnd + 4'h1;
            if (rnd == sih_pkg::AES_ROUNDS) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // sih_aes
`default_nettype wire

// File: rtl/sih_pkg.sv
// Purpose: shared constants, carrier types and GF(2^8) helpers for the security unit
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: byte 0 of a 16-byte block sits in bits [127:120]
`default_nettype none
package sih_pkg;
   // Local memory limits, bad increment size and AES constants
   localparam logic [11:0] INC_ADDR_MAX = 12'h3FC;
   localparam logic [1:0] INC_SIZE_BAD = 2'h3;
   localparam logic [4:0] BLOCK_LEN = 5'h10;
   localparam logic [3:0] AES_ROUNDS = 4'hA;
   localparam logic [7:0] AES_RCON_INIT = 8'h01;
   // Register byte offsets
   localparam logic [12:0] REG_OPER_A = 13'h0000;
   localparam logic [12:0] REG_OPER_B = 13'h0004;
   localparam logic [12:0] REG_ISSUE = 13'h0008;
   localparam logic [12:0] REG_FLAGS = 13'h000C;
   localparam logic [12:0] REG_RESULT = 13'h0010;
   localparam logic [12:0] RAM_BASE = 13'h1000;
   // Field positions
   localparam int OPA_SRC_LSB = 0;
   localparam int OPA_DST_LSB = 16;
   localparam int OPB_KEY_LSB = 0;
   localparam int OPB_CNT_LSB = 8;
   localparam int ISSUE_OP_BIT = 0;
   localparam int ISSUE_PRIO_BIT = 4;
   localparam int FLG_BUSY_LSB = 0;
   localparam int FLG_STICKY_LSB = 2;
   localparam int FLG_STATE_LSB = 8;
   localparam int FLG_CUR_BIT = 11;
   localparam logic [31:0] OPA_MASK = 32'h0FFF_0FFF;
   localparam logic [31:0] OPB_MASK = 32'h0000_0FFF;
   // Reset values
   localparam logic [31:0] OPER_A_RST = 32'h0000_0000;
   localparam logic [31:0] OPER_B_RST = 32'h0000_0000;
   // Status codes returned per instruction
   localparam logic [7:0] STAT_OK = 8'h00;
   localparam logic [7:0] STAT_MISUSE = 8'h01;
   localparam logic [7:0] STAT_RANGE = 8'h02;

   typedef enum logic [0:0] {
      OP_INC = 1'b0,
      OP_ECB = 1'b1
   } sih_op_t;

   typedef struct packed {
      sih_op_t op;
      logic prio;
      logic [3:0] cnt;
      logic [7:0] key;
      logic [11:0] src;
      logic [11:0] dst;
   } sih_instr_t;

   function automatic logic [7:0] sih_xtime(input logic [7:0] x);
      return {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
   endfunction

   function automatic logic [7:0] sih_gmul(input logic [7:0] x, input logic [7:0] y);
      logic [7:0] acc;
      logic [7:0] v;
      acc = 8'h00;
      v = x;
      for (int i = 0; i < 8; i++) begin
         if (y[i]) acc = acc ^ v;
         v = sih_xtime(v);
      end
      return acc;
   endfunction

   // Inverse as x^254, then the affine map; avoids a 256-entry table
   function automatic logic [7:0] sih_sbox(input logic [7:0] x);
      logic [7:0] inv;
      logic [7:0] sq;
      inv = 8'h01;
      sq = x;
      for (int i = 1; i < 8; i++) begin
         sq = sih_gmul(sq, sq);
         inv = sih_gmul(inv, sq);
      end
      return inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]} ^ {inv[4:0], inv[7:5]}
         ^ {inv[3:0], inv[7:4]} ^ 8'h63;
   endfunction

   function automatic logic [31:0] sih_mixcol(input logic [31:0] col);
      logic [7:0] a0;
      logic [7:0] a1;
      logic [7:0] a2;
      logic [7:0] a3;
      {a0, a1, a2, a3} = col;
      return {sih_xtime(a0) ^ sih_xtime(a1) ^ a1 ^ a2 ^ a3,
              a0 ^ sih_xtime(a1) ^ sih_xtime(a2) ^ a2 ^ a3,
              a0 ^ a1 ^ sih_xtime(a2) ^ sih_xtime(a3) ^ a3,
              sih_xtime(a0) ^ a0 ^ a1 ^ a2 ^ sih_xtime(a3)};
   endfunction
endpackage
`default_nettype wire

// File: rtl/sih_ram.sv
// Purpose: local byte memory with a 16-byte engine port and a 32-bit bus port
// Assumes: the engine never writes in the same cycle as the bus
// Notes: reads are combinational; addresses wrap at the memory size
`default_nettype none
module sih_ram #(
   parameter int BYTES = 1024
) (
   input wire logic clock,
   input wire logic [11:0] blk_addr,
   input wire logic [15:0] blk_we,
   input wire logic [127:0] blk_wdata,
   output logic [127:0] blk_rdata,
   input wire logic [11:0] word_addr,
   input wire logic [3:0] word_we,
   input wire logic [31:0] word_wdata,
   output logic [31:0] word_rdata
);
   localparam int AW = $clog2(BYTES);
   logic [7:0] mem [BYTES];

   function automatic logic [AW-1:0] wrap(input logic [11:0] base, input int off);
      logic [11:0] a;
      a = base + 12'(off);
      return a[AW-1:0];
   endfunction

   always_comb begin
      for (int i = 0; i < 16; i++) blk_rdata[127 - 8 * i -: 8] = mem[wrap(blk_addr, i)];
      for (int j = 0; j < 4; j++) word_rdata[8 * j +: 8] = mem[wrap(word_addr, j)];
   end

   // Engine port last, so it would win a collision
   always_ff @(posedge clock) begin
      for (int j = 0; j < 4; j++) begin
         if (word_we[j]) mem[wrap(word_addr, j)] <= word_wdata[8 * j +: 8];
      end
      for (int i = 0; i < 16; i++) begin
         if (blk_we[i]) mem[wrap(blk_addr, i)] <= blk_wdata[127 - 8 * i -: 8];
      end
   end
endmodule // sih_ram
`default_nettype wire

// File: rtl/sih_unit.sv
// Purpose: security instruction unit: counter increment and AES-128 ECB block
// Assumes: Avalon-MM slave with waitrequest, 50 MHz clock, synchronous active-high reset
// Notes: one engine serves both priority slots, high priority first
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`default_nettype none
module sih_unit #(
   parameter int RAM_BYTES = 1024
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [12:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic low_priority_complete,
   output logic high_priority_complete,
   output logic misuse_fault,
   output logic address_range_fault
);
   localparam logic [12:0] MEM_TOP = 13'(RAM_BYTES - 1);
   localparam logic [12:0] RAM_END = sih_pkg::RAM_BASE + 13'(RAM_BYTES);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CHECK = 3'b001,
      ST_INC = 3'b010,
      ST_KEY = 3'b011,
      ST_TEXT = 3'b100,
      ST_AES = 3'b101,
      ST_WRITE = 3'b110,
      ST_DONE = 3'b111
   } sih_state_t;

   // Bus side
   logic bus_req;
   logic bus_ack;
   logic bus_done;
   logic sel_ram;
   logic sel_opa;
   logic sel_opb;
   logic sel_issue;
   logic sel_flags;
   logic sel_result;
   logic [31:0] rd_mux;
   logic [31:0] oper_a;
   logic [31:0] oper_b;
   logic [3:0] ram_word_we;
   logic [31:0] ram_word_rdata;

   // Instruction slots, index 0 low and 1 high priority
   logic [1:0] slot_busy;
   sih_pkg::sih_instr_t slot_instr [2];
   logic [7:0] slot_status [2];
   sih_pkg::sih_instr_t new_instr;
   logic issue_req;
   logic issue_clash;

   // Engine
   sih_state_t state;
   sih_state_t next_state;
   logic cur;
   sih_pkg::sih_instr_t ins;
   logic [7:0] status;
   logic chk_misuse;
   logic chk_range;
   logic eng_wr;
   logic [11:0] eng_addr;
   logic [15:0] eng_we;
   logic [127:0] eng_wdata;
   logic [127:0] eng_rdata;
   logic [127:0] key_q;
   logic [127:0] plain;
   logic [31:0] inc_word;
   logic [3:0] inc_mask;
   logic aes_busy;
   logic aes_done;
   logic [127:0] aes_out;

   // Events and sticky flags: done low, done high, misuse, range
   logic [3:0] ev;
   logic [3:0] sticky;
   logic [3:0] sticky_clr;

   function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8 * i +: 8] = wd[8 * i +: 8];
      end
      return r;
   endfunction

   function automatic logic region_ok(input logic [11:0] base, input logic [4:0] len);
      logic [12:0] last;
      last = {1'b0, base} + {8'h00, len} - 13'h0001;
      return last <= MEM_TOP;
   endfunction

   // ---------------- Bus slave ----------------
   assign bus_req = avs_read || avs_write;
   // A bus RAM write waits while the engine writes, so the two ports never collide
   assign avs_waitrequest = bus_req && (!bus_ack || (avs_write && sel_ram && eng_wr));
   assign bus_done = bus_req && !avs_waitrequest;

   always_comb begin
      sel_ram = 1'b0;
      sel_opa = 1'b0;
      sel_opb = 1'b0;
      sel_issue = 1'b0;
      sel_flags = 1'b0;
      sel_result = 1'b0;
      if (avs_address >= sih_pkg::RAM_BASE && avs_address < RAM_END) begin
         sel_ram = 1'b1;
      end else if (avs_address == sih_pkg::REG_OPER_A) begin
         sel_opa = 1'b1;
      end else if (avs_address == sih_pkg::REG_OPER_B) begin
         sel_opb = 1'b1;
      end else if (avs_address == sih_pkg::REG_ISSUE) begin
         sel_issue = 1'b1;
      end else if (avs_address == sih_pkg::REG_FLAGS) begin
         sel_flags = 1'b1;
      end else if (avs_address == sih_pkg::REG_RESULT) begin
         sel_result = 1'b1;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ram) begin
         rd_mux = ram_word_rdata;
      end else if (sel_opa) begin
         rd_mux = oper_a;
      end else if (sel_opb) begin
         rd_mux = oper_b;
      end else if (sel_flags) begin
         rd_mux[sih_pkg::FLG_BUSY_LSB +: 2] = slot_busy;
         rd_mux[sih_pkg::FLG_STICKY_LSB +: 4] = sticky;
         rd_mux[sih_pkg::FLG_STATE_LSB +: 3] = state;
         rd_mux[sih_pkg::FLG_CUR_BIT] = cur;
      end else if (sel_result) begin
         rd_mux = {16'h0000, slot_status[1], slot_status[0]};
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         bus_ack <= bus_req && !bus_done;
         if (avs_read && !bus_ack) avs_readdata <= rd_mux;
      end
   end

   assign ram_word_we = (bus_done && avs_write && sel_ram) ? avs_byteenable : 4'h0;

   always_ff @(posedge clock) begin
      if (srst) begin
         oper_a <= sih_pkg::OPER_A_RST;
         oper_b <= sih_pkg::OPER_B_RST;
      end else if (bus_done && avs_write) begin
         if (sel_opa) oper_a <= merge_be(oper_a, avs_writedata, avs_byteenable) & sih_pkg::OPA_MASK;
         if (sel_opb) oper_b <= merge_be(oper_b, avs_writedata, avs_byteenable) & sih_pkg::OPB_MASK;
      end
   end

   // ---------------- Issue and slots ----------------
   always_comb begin
      new_instr.op = sih_pkg::sih_op_t'(avs_writedata[sih_pkg::ISSUE_OP_BIT]);
      new_instr.prio = avs_writedata[sih_pkg::ISSUE_PRIO_BIT];
      new_instr.cnt = oper_b[sih_pkg::OPB_CNT_LSB +: 4];
      new_instr.key = oper_b[sih_pkg::OPB_KEY_LSB +: 8];
      new_instr.src = oper_a[sih_pkg::OPA_SRC_LSB +: 12];
      new_instr.dst = oper_a[sih_pkg::OPA_DST_LSB +: 12];
   end

   assign issue_req = bus_done && avs_write && sel_issue && avs_byteenable[0];
   // The running or queued instruction keeps its slot; the new one is dropped
   assign issue_clash = issue_req && slot_busy[new_instr.prio];

   always_ff @(posedge clock) begin
      if (srst) begin
         slot_busy <= 2'b00;
         slot_instr[0] <= '0;
         slot_instr[1] <= '0;
         slot_status[0] <= sih_pkg::STAT_OK;
         slot_status[1] <= sih_pkg::STAT_OK;
      end else begin
         if (state == ST_DONE) begin
            slot_busy[cur] <= 1'b0;
            slot_status[cur] <= status;
         end
         if (issue_req && !issue_clash) begin
            slot_busy[new_instr.prio] <= 1'b1;
            slot_instr[new_instr.prio] <= new_instr;
         end
      end
   end

   // ---------------- Engine ----------------
   always_comb begin
      chk_misuse = (ins.op == sih_pkg::OP_INC) && (ins.cnt[1:0] == sih_pkg::INC_SIZE_BAD);
      if (ins.op == sih_pkg::OP_INC) begin
         chk_range = ins.src > sih_pkg::INC_ADDR_MAX;
      end else begin
         chk_range = !region_ok({ins.key, 4'h0}, sih_pkg::BLOCK_LEN)
            || !region_ok(ins.src, sih_pkg::BLOCK_LEN - {1'b0, ins.cnt})
            || !region_ok(ins.dst, sih_pkg::BLOCK_LEN);
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (slot_busy != 2'b00) next_state = ST_CHECK;
         ST_CHECK: begin
            if (chk_misuse || chk_range) next_state = ST_DONE;
            else if (ins.op == sih_pkg::OP_INC) next_state = ST_INC;
            else next_state = ST_KEY;
         end
         ST_INC: next_state = ST_DONE;
         ST_KEY: next_state = ST_TEXT;
         ST_TEXT: next_state = ST_AES;
         ST_AES: if (aes_done) next_state = ST_WRITE;
         ST_WRITE: next_state = ST_DONE;
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) state <= ST_IDLE;
      else state <= next_state;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cur <= 1'b0;
         ins <= '0;
         status <= sih_pkg::STAT_OK;
         key_q <= 128'h0;
      end else begin
         // High priority is served first when both slots wait
         if (state == ST_IDLE) begin
            cur <= slot_busy[1];
            ins <= slot_instr[slot_busy[1]];
         end
         if (state == ST_CHECK) begin
            if (chk_misuse) status <= sih_pkg::STAT_MISUSE;
            else if (chk_range) status <= sih_pkg::STAT_RANGE;
            else status <= sih_pkg::STAT_OK;
         end
         if (state == ST_KEY) key_q <= eng_rdata;
      end
   end

   always_comb begin
      case (state)
         ST_KEY: eng_addr = {ins.key, 4'h0};
         ST_WRITE: eng_addr = ins.dst;
         default: eng_addr = ins.src;
      endcase
   end

   always_comb begin
      case (ins.cnt[1:0])
         2'h0: inc_mask = 4'b0001;
         2'h1: inc_mask = 4'b0011;
         default: inc_mask = 4'b1111;
      endcase
   end

   // Counter is little endian; all four bytes are summed but only 2^size are stored
   assign inc_word = {eng_rdata[103:96], eng_rdata[111:104], eng_rdata[119:112],
                      eng_rdata[127:120]} + 32'h0000_0001;

   always_comb begin
      eng_wdata = aes_out;
      eng_we = 16'h0000;
      if (state == ST_INC) begin
         eng_wdata = 128'h0;
         for (int i = 0; i < 4; i++) eng_wdata[127 - 8 * i -: 8] = inc_word[8 * i +: 8];
         eng_we = {12'h000, inc_mask};
      end else if (state == ST_WRITE) begin
         eng_we = 16'hFFFF;
      end
   end

   assign eng_wr = (state == ST_INC) || (state == ST_WRITE);

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (5'(i) < sih_pkg::BLOCK_LEN - {1'b0, ins.cnt}) plain[127 - 8 * i -: 8] =
            eng_rdata[127 - 8 * i -: 8];
         else plain[127 - 8 * i -: 8] = 8'h00;
      end
   end

   sih_ram #(
      .BYTES(RAM_BYTES)
   ) u_ram (
      .clock(clock),
      .blk_addr(eng_addr),
      .blk_we(eng_we),
      .blk_wdata(eng_wdata),
      .blk_rdata(eng_rdata),
      .word_addr({avs_address[11:2], 2'b00}),
      .word_we(ram_word_we),
      .word_wdata(avs_writedata),
      .word_rdata(ram_word_rdata)
   );

   sih_aes u_aes (
      .clock(clock),
      .srst(srst),
      .start(state == ST_TEXT),
      .key(key_q),
      .plain(plain),
      .busy(aes_busy),
      .done(aes_done),
      .cipher(aes_out)
   );

   // ---------------- Events ----------------
   always_comb begin
      ev[0] = (state == ST_DONE) && !cur;
      ev[1] = (state == ST_DONE) && cur;
      ev[2] = issue_clash || ((state == ST_CHECK) && chk_misuse);
      ev[3] = (state == ST_CHECK) && !chk_misuse && chk_range;
   end

   assign sticky_clr = (bus_done && avs_write && sel_flags && avs_byteenable[0])
      ? avs_writedata[sih_pkg::FLG_STICKY_LSB +: 4] : 4'h0;

   // A new event in the clearing cycle stays set
   always_ff @(posedge clock) begin
      if (srst) sticky <= 4'h0;
      else sticky <= (sticky & ~sticky_clr) | ev;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         low_priority_complete <= 1'b0;
         high_priority_complete <= 1'b0;
         misuse_fault <= 1'b0;
         address_range_fault <= 1'b0;
      end else begin
         low_priority_complete <= ev[0];
         high_priority_complete <= ev[1];
         misuse_fault <= ev[2];
         address_range_fault <= ev[3];
      end
   end
endmodule // sih_unit
`default_nettype wire

// File: sim/sih_host.sv
// Purpose: host controller model driving the register bus
// Assumes: one transfer at a time
// Notes: released address and data are inverted so stale values never look valid
`default_nettype none
module sih_host (
   input wire logic clock,
   output logic [12:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = 13'h0000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
   end
   // Waitrequest is read at the rising edge, before that edge's updates land
   task automatic xfer(input logic rd, input logic [12:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clock);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      @(posedge clock);
      while (avs_waitrequest) @(posedge clock);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask
endmodule // sih_host
`default_nettype wire

// File: sim/sih_unit_properties.sv
// Purpose: port-level checks of the security instruction unit
// Assumes: one clock domain, synchronous active-high reset
// Notes: sees only the top module's ports
`default_nettype none
module sih_unit_properties (
   input wire logic clock,
   input wire logic srst,
   input wire logic [12:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic low_priority_complete,
   input wire logic high_priority_complete,
   input wire logic misuse_fault,
   input wire logic address_range_fault
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("bus answered in the request's first cycle");
   wait_bound_a: assert property ((avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
      else $error("bus answer too late");
   read_hold_a: assert property (avs_read && !avs_waitrequest |=> $stable(avs_readdata))
      else $error("read data moved after the answer");
   low_pulse_a: assert property (low_priority_complete |=> !low_priority_complete)
      else $error("low completion longer than one cycle");
   high_pulse_a: assert property (high_priority_complete |=> !high_priority_complete)
      else $error("high completion longer than one cycle");
   one_engine_a: assert property (!(low_priority_complete && high_priority_complete))
      else $error("both completions at once");
   range_done_a: assert property (address_range_fault |=>
      (low_priority_complete || high_priority_complete))
      else $error("range fault without completion");
   issue_end_a: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == sih_pkg::REG_ISSUE |-> ##[1:40]
      (low_priority_complete || high_priority_complete || misuse_fault))
      else $error("issued instruction neither ran nor was refused");
endmodule // sih_unit_properties
`default_nettype wire

// File: sim/tb_sih_unit.sv
// Purpose: self-checking bench for the security instruction unit
// Assumes: 50 MHz clock, host model on the register bus
// Notes: AES checked on one known-answer block only; a full model would not fit
`default_nettype none
module tb_sih_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [12:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, lo_done, hi_done, misuse, range_f;
   logic [31:0] avs_writedata, avs_readdata, rdat, v, r, junk;
   logic [3:0] avs_byteenable;
   logic [11:0] a;
   logic [47:0] t;
   logic [31:0] seed = 32'h0000_4E05;
   int miscompares = 0, n_tests = 0, n_lo = 0, n_hi = 0, e_lo = 0, e_hi = 0;
   int n_mis = 0, n_rng = 0;
   logic [31:0] ct [4] = '{32'hD8E0_C469, 32'h3004_7B6A, 32'h80B7_CDD8, 32'h5AC5_B470};
   // op, A, E, count, key index, status
   logic [47:0] cases [6] = '{48'h0_100_000_3_00_01, 48'h0_3FD_000_0_00_02,
      48'h1_3F4_300_4_00_00, 48'h1_3F4_300_0_00_02, 48'h1_000_3F1_0_00_02,
      48'h1_000_300_0_40_02};
   sih_unit sih_unit_i (.clock(clock), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .low_priority_complete(lo_done),
      .high_priority_complete(hi_done), .misuse_fault(misuse), .address_range_fault(range_f));
   sih_host sih_host_i (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   initial begin
      forever #10 clock = ~clock;
   end
   always @(negedge clock) begin
      if (lo_done === 1'b1) n_lo++;
      if (hi_done === 1'b1) n_hi++;
      if (misuse === 1'b1) n_mis++;
      if (range_f === 1'b1) n_rng++;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] inc_exp(input logic [31:0] w, input logic [1:0] s);
      logic [31:0] m;
      m = (s == 2'h0) ? 32'hFF : (s == 2'h1) ? 32'hFFFF : 32'hFFFF_FFFF;
      return (w & ~m) | ((w + 32'h1) & m);
   endfunction
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wr(input logic [12:0] ad, input logic [31:0] d);
      sih_host_i.xfer(1'b0, ad, d, junk);
   endtask
   task automatic rd(input logic [12:0] ad);
      sih_host_i.xfer(1'b1, ad, 32'h0, rdat);
   endtask
   task automatic run(input sih_pkg::sih_op_t op, input logic p, input logic [11:0] aa,
         input logic [11:0] e, input logic [3:0] c, input logic [7:0] k);
      wr(sih_pkg::REG_OPER_A, {4'h0, e, 4'h0, aa});
      wr(sih_pkg::REG_OPER_B, {20'h0, c, k});
      wr(sih_pkg::REG_ISSUE, {27'h0, p, 3'h0, op});
      if (p) e_hi++;
      else e_lo++;
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 60; i++) begin
         rd(sih_pkg::REG_FLAGS);
         if (rdat[1:0] === 2'b00) return;
      end
      chk("busy", 32'h0, rdat);
   endtask
   task automatic stat(input logic p, input logic [7:0] x);
      rd(sih_pkg::REG_RESULT);
      chk("status", {24'h0, x}, {24'h0, p ? rdat[15:8] : rdat[7:0]});
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      // Carry corner at the top legal base first, then random words and bases
      for (int i = 0; i < 6; i++) begin
         r = xs();
         a = (i < 3) ? 12'h3FC : {2'h0, r[9:2], 2'h0};
         v = (i < 3) ? 32'h00FF_FFFF : xs();
         wr(sih_pkg::RAM_BASE + 13'(a), v);
         run(sih_pkg::OP_INC, i[0], a, 12'h000, 4'(i % 3), 8'h00);
         wait_idle();
         rd(sih_pkg::RAM_BASE + 13'(a));
         chk("inc word", inc_exp(v, 2'(i % 3)), rdat);
         stat(i[0], sih_pkg::STAT_OK);
      end
      for (int i = 0; i < 6; i++) begin
         t = cases[i];
         run(sih_pkg::sih_op_t'(t[44]), i[0], t[43:32], t[31:20], t[19:16], t[15:8]);
         wait_idle();
         stat(i[0], t[7:0]);
      end
      rd(sih_pkg::REG_FLAGS);
      chk("sticky", 32'h3, 32'(rdat[5:4]));
      wr(sih_pkg::REG_FLAGS, 32'h0000_003C);
      for (int i = 0; i < 4; i++) begin
         wr(sih_pkg::RAM_BASE + 13'h020 + 13'(4 * i), 32'h0302_0100 + 32'h0404_0404 * i);
         wr(sih_pkg::RAM_BASE + 13'h100 + 13'(4 * i), 32'h3322_1100 + 32'h4444_4444 * i);
      end
      wr(sih_pkg::RAM_BASE + 13'h380, 32'h0);
      // Second low issue lands while the block is in flight; high still runs
      run(sih_pkg::OP_ECB, 1'b0, 12'h100, 12'h200, 4'h0, 8'h02);
      wr(sih_pkg::REG_ISSUE, 32'h0000_0000);
      wr(sih_pkg::REG_OPER_A, 32'h0000_0380);
      wr(sih_pkg::REG_ISSUE, 32'h0000_0010);
      e_hi++;
      wait_idle();
      rd(sih_pkg::REG_FLAGS);
      chk("misuse flag", 32'h1, 32'(rdat[5:4]));
      rd(sih_pkg::RAM_BASE + 13'h380);
      chk("high inc", 32'h1, rdat);
      for (int i = 0; i < 4; i++) begin
         rd(sih_pkg::RAM_BASE + 13'h200 + 13'(4 * i));
         chk("cipher", ct[i], rdat);
      end
      stat(1'b0, sih_pkg::STAT_OK);
      chk("low events", 32'(e_lo), 32'(n_lo));
      chk("high events", 32'(e_hi), 32'(n_hi));
      chk("misuse events", 32'h2, 32'(n_mis));
      chk("range events", 32'h4, 32'(n_rng));
      end_of_test();
   end
endmodule // tb_sih_unit
bind sih_unit sih_unit_properties sih_unit_properties_i (.clock(clock), .srst(srst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .low_priority_complete(low_priority_complete),
   .high_priority_complete(high_priority_complete), .misuse_fault(misuse_fault),
   .address_range_fault(address_range_fault));
`default_nettype wire
